// ==== pkg/opcode_decode_map.vh ====
// opcode decoder constants: classes, opcode patterns, states
// What this block does
// - a4/a5 string copy, a6/a7 string compare, f2/f3 repeat prefix with z bit.
// - ae/af is a single-byte string scan; bit 0 selects word width.
// - ac/ad is a single-byte string load into accumulator; bit 0 selects width.
// - aa/ab is a single-byte string store from accumulator; bit 0 selects width.
// - 3f is the ascii adjust after subtract, no operand bytes.
// - 2f is the decimal adjust after subtract, no operand bytes.
// - d4 then 0a is the ascii adjust after multiply.
// - d5 then 0a is the ascii adjust before divide.
// - 98 extends byte to word; 99 extends word to double word.
// - f6/f7 reg 100 unsigned multiply, 101 signed; operand from mod r/m.
// - f6/f7 reg 110 unsigned divide, 111 signed divide; width from bit 0.
// - f6/f7 reg 010 invert; reg 000 test immediate, one or two data bytes.
// - d0-d3 shift/rotate; reg selects rotate, carry rotate or shift kind.
// - 84/85 with mod r/m byte is a flag-only and, no result.
// - a8/a9 is flag-only and of accumulator with one or two data bytes.
// - c3 near return, cb far return, c2 near return plus 16-bit immediate.
`ifndef OPCODE_DECODE_MAP_VH
`define OPCODE_DECODE_MAP_VH

// ----------------------------------------
// decoder states
// ----------------------------------------
`define ST_OPCODE 2'h0
`define ST_MODRM 2'h1
`define ST_TRAIL 2'h2

// ----------------------------------------
// opcode groups
// ----------------------------------------
`define GRP_DIRECT 3'h0
`define GRP_UNARY 3'h1
`define GRP_SHIFT 3'h2
`define GRP_INDIR 3'h3
`define GRP_LOGIMM 3'h4
`define GRP_ASCII2 3'h5
`define GRP_TESTREG 3'h6

// ----------------------------------------
// opcode masks and patterns
// ----------------------------------------
`define MASK_W 8'hFE
`define MASK_VW 8'hFC
`define MASK_ALL 8'hFF
`define OPC_STR_COPY 8'hA4
`define OPC_STR_CMP 8'hA6
`define OPC_REPEAT 8'hF2
`define OPC_STR_SCAN 8'hAE
`define OPC_STR_LOAD 8'hAC
`define OPC_STR_STORE 8'hAA
`define OPC_ADJ_SUB 8'h3F
`define OPC_DEC_SUB 8'h2F
`define OPC_ADJ_MULT 8'hD4
`define OPC_ADJ_DIV 8'hD5
`define OPC_ADJ_TAIL 8'h0A
`define OPC_EXT_BYTE 8'h98
`define OPC_EXT_WORD 8'h99
`define OPC_UNARY 8'hF6
`define OPC_SHIFT 8'hD0
`define OPC_TEST_REG 8'h84
`define OPC_TEST_ACC 8'hA8
`define OPC_RET_NEAR 8'hC3
`define OPC_RET_FAR 8'hCB
`define OPC_RET_IMM 8'hC2
`define OPC_CALL_NEAR 8'hE8
`define OPC_JMP_NEAR 8'hE9
`define OPC_JMP_SHORT 8'hEB
`define OPC_CALL_FAR 8'h9A
`define OPC_JMP_FAR 8'hEA
`define OPC_INDIR 8'hFF
`define OPC_LOGIMM 8'h80

// ----------------------------------------
// trailing byte counts
// ----------------------------------------
`define LEN_NONE 3'h0
`define LEN_BYTE 3'h1
`define LEN_WORD 3'h2
`define LEN_FAR 3'h4

// ----------------------------------------
// operation classes
// ----------------------------------------
`define CL_UNSUPPORTED 6'h00
`define CL_STRING_COPY 6'h01
`define CL_STRING_COMPARE 6'h02
`define CL_STRING_SCAN 6'h03
`define CL_STRING_LOAD 6'h04
`define CL_STRING_STORE 6'h05
`define CL_REPEAT_PREFIX 6'h06
`define CL_ASCII_ADJUST_SUB 6'h07
`define CL_DECIMAL_ADJUST_SUB 6'h08
`define CL_ASCII_ADJUST_MULT 6'h09
`define CL_ASCII_ADJUST_DIV 6'h0A
`define CL_SIGN_EXTEND_BYTE 6'h0B
`define CL_SIGN_EXTEND_WORD 6'h0C
`define CL_MULTIPLY_OP 6'h0D
`define CL_SIGNED_MULTIPLY 6'h0E
`define CL_DIVIDE_OP 6'h0F
`define CL_SIGNED_DIVIDE 6'h10
`define CL_INVERT 6'h11
`define CL_TEST_IMM 6'h12
`define CL_ROTATE_LEFT_OP 6'h13
`define CL_ROTATE_RIGHT_OP 6'h14
`define CL_ROTATE_CARRY_LEFT 6'h15
`define CL_ROTATE_CARRY_RIGHT 6'h16
`define CL_SHIFT_LEFT 6'h17
`define CL_LOGICAL_RIGHT_SHIFT 6'h18
`define CL_ARITH_RIGHT_SHIFT 6'h19
`define CL_TEST_REG 6'h1A
`define CL_TEST_ACC 6'h1B
`define CL_RETURN_NEAR 6'h1C
`define CL_RETURN_FAR 6'h1D
`define CL_RETURN_IMM 6'h1E
`define CL_CALL_NEAR 6'h1F
`define CL_JUMP_NEAR 6'h20
`define CL_JUMP_SHORT 6'h21
`define CL_CALL_FAR 6'h22
`define CL_JUMP_FAR 6'h23
`define CL_CALL_NEAR_IND 6'h24
`define CL_CALL_FAR_IND 6'h25
`define CL_JUMP_NEAR_IND 6'h26
`define CL_JUMP_FAR_IND 6'h27
`define CL_AND_IMM 6'h28
`define CL_OR_IMM 6'h29
`define CL_XOR_IMM 6'h2A

`endif

// ==== logic/opcode_classify.v ====
// first-byte classifier for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decode_map.vh"

module opcode_classify (
  input  wire [7:0] opcode,
  output reg  [5:0] base_class,
  output reg  [2:0] group,
  output reg  [2:0] imm_len
);

  // masked pattern compare
  function match;
    input [7:0] b;
    input [7:0] mask;
    input [7:0] pat;
    begin
      match = ((b & mask) == pat);
    end
  endfunction

  wire w = opcode[0];

  // ----------------------------------------
  // first byte lookup
  // ----------------------------------------
  always @* begin
    base_class = `CL_UNSUPPORTED;
    group      = `GRP_DIRECT;
    imm_len    = `LEN_NONE;
    if (match(opcode, `MASK_W, `OPC_STR_COPY))
      base_class = `CL_STRING_COPY;
    else if (match(opcode, `MASK_W, `OPC_STR_CMP))
      base_class = `CL_STRING_COMPARE;
    else if (match(opcode, `MASK_W, `OPC_REPEAT))
      base_class = `CL_REPEAT_PREFIX;
    else if (match(opcode, `MASK_W, `OPC_STR_SCAN))
      base_class = `CL_STRING_SCAN;
    else if (match(opcode, `MASK_W, `OPC_STR_LOAD))
      base_class = `CL_STRING_LOAD;
    else if (match(opcode, `MASK_W, `OPC_STR_STORE))
      base_class = `CL_STRING_STORE;
    else if (match(opcode, `MASK_ALL, `OPC_ADJ_SUB))
      base_class = `CL_ASCII_ADJUST_SUB;
    else if (match(opcode, `MASK_ALL, `OPC_DEC_SUB))
      base_class = `CL_DECIMAL_ADJUST_SUB;
    else if (match(opcode, `MASK_ALL, `OPC_ADJ_MULT)) begin
      base_class = `CL_ASCII_ADJUST_MULT;
      group      = `GRP_ASCII2;
    end else if (match(opcode, `MASK_ALL, `OPC_ADJ_DIV)) begin
      base_class = `CL_ASCII_ADJUST_DIV;
      group      = `GRP_ASCII2;
    end else if (match(opcode, `MASK_ALL, `OPC_EXT_BYTE))
      base_class = `CL_SIGN_EXTEND_BYTE;
    else if (match(opcode, `MASK_ALL, `OPC_EXT_WORD))
      base_class = `CL_SIGN_EXTEND_WORD;
    else if (match(opcode, `MASK_W, `OPC_UNARY))
      group = `GRP_UNARY;
    else if (match(opcode, `MASK_VW, `OPC_SHIFT))
      group = `GRP_SHIFT;
    else if (match(opcode, `MASK_W, `OPC_TEST_REG)) begin
      base_class = `CL_TEST_REG;
      group      = `GRP_TESTREG;
    end else if (match(opcode, `MASK_W, `OPC_TEST_ACC)) begin
      base_class = `CL_TEST_ACC;
      imm_len    = w ? `LEN_WORD : `LEN_BYTE;
    end else if (match(opcode, `MASK_ALL, `OPC_RET_NEAR))
      base_class = `CL_RETURN_NEAR;
    else if (match(opcode, `MASK_ALL, `OPC_RET_FAR))
      base_class = `CL_RETURN_FAR;
    else if (match(opcode, `MASK_ALL, `OPC_RET_IMM)) begin
      base_class = `CL_RETURN_IMM;
      imm_len    = `LEN_WORD;
    end else if (match(opcode, `MASK_ALL, `OPC_CALL_NEAR)) begin
      base_class = `CL_CALL_NEAR;
      imm_len    = `LEN_WORD;
    end else if (match(opcode, `MASK_ALL, `OPC_JMP_NEAR)) begin
      base_class = `CL_JUMP_NEAR;
      imm_len    = `LEN_WORD;
    end else if (match(opcode, `MASK_ALL, `OPC_JMP_SHORT)) begin
      base_class = `CL_JUMP_SHORT;
      imm_len    = `LEN_BYTE;
    end else if (match(opcode, `MASK_ALL, `OPC_CALL_FAR)) begin
      base_class = `CL_CALL_FAR;
      imm_len    = `LEN_FAR;
    end else if (match(opcode, `MASK_ALL, `OPC_JMP_FAR)) begin
      base_class = `CL_JUMP_FAR;
      imm_len    = `LEN_FAR;
    end else if (match(opcode, `MASK_ALL, `OPC_INDIR))
      group = `GRP_INDIR;
    else if (match(opcode, `MASK_W, `OPC_LOGIMM))
      group = `GRP_LOGIMM;
  end

endmodule // opcode_classify

`default_nettype wire

// ==== logic/opcode_decode.v ====
// byte-serial opcode decoder for arith, logic, string and control ops
`timescale 1ns/1ps
`default_nettype none
`include "opcode_decode_map.vh"

module opcode_decode (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  output reg         op_valid_r,
  output reg  [5:0]  op_class_r,
  output reg         word_op_r,
  output reg         count_in_reg_r,
  output reg         repeat_zero_r,
  output reg         has_modrm_r,
  output reg  [7:0]  opcode_r,
  output reg  [7:0]  modrm_r,
  output reg  [1:0]  disp_len_r,
  output reg  [2:0]  trail_len_r,
  output reg  [31:0] operand_r
);

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // displacement bytes implied by a mod r/m byte
  function [1:0] disp_bytes;
    input [7:0] mrm;
    begin
      case (mrm[7:6])
        2'h1:    disp_bytes = 2'h1;
        2'h2:    disp_bytes = 2'h2;
        2'h0:    disp_bytes = (mrm[2:0] == 3'h6) ? 2'h2 : 2'h0;
        default: disp_bytes = 2'h0;
      endcase
    end
  endfunction

  // class from group and the second byte
  function [5:0] second_class;
    input [2:0] grp;
    input [7:0] sec;
    input [5:0] base;
    begin
      case (grp)
        `GRP_UNARY: begin
          case (sec[5:3])
            3'h0:    second_class = `CL_TEST_IMM;
            3'h2:    second_class = `CL_INVERT;
            3'h4:    second_class = `CL_MULTIPLY_OP;
            3'h5:    second_class = `CL_SIGNED_MULTIPLY;
            3'h6:    second_class = `CL_DIVIDE_OP;
            3'h7:    second_class = `CL_SIGNED_DIVIDE;
            default: second_class = `CL_UNSUPPORTED;
          endcase
        end
        `GRP_SHIFT: begin
          case (sec[5:3])
            3'h0:    second_class = `CL_ROTATE_LEFT_OP;
            3'h1:    second_class = `CL_ROTATE_RIGHT_OP;
            3'h2:    second_class = `CL_ROTATE_CARRY_LEFT;
            3'h3:    second_class = `CL_ROTATE_CARRY_RIGHT;
            3'h4:    second_class = `CL_SHIFT_LEFT;
            3'h5:    second_class = `CL_LOGICAL_RIGHT_SHIFT;
            3'h7:    second_class = `CL_ARITH_RIGHT_SHIFT;
            default: second_class = `CL_UNSUPPORTED;
          endcase
        end
        `GRP_INDIR: begin
          case (sec[5:3])
            3'h2:    second_class = `CL_CALL_NEAR_IND;
            3'h3:    second_class = `CL_CALL_FAR_IND;
            3'h4:    second_class = `CL_JUMP_NEAR_IND;
            3'h5:    second_class = `CL_JUMP_FAR_IND;
            default: second_class = `CL_UNSUPPORTED;
          endcase
        end
        `GRP_LOGIMM: begin
          case (sec[5:3])
            3'h4:    second_class = `CL_AND_IMM;
            3'h5:    second_class = `CL_OR_IMM;
            3'h6:    second_class = `CL_XOR_IMM;
            default: second_class = `CL_UNSUPPORTED;
          endcase
        end
        `GRP_ASCII2: begin
          if (sec == `OPC_ADJ_TAIL)
            second_class = base;
          else
            second_class = `CL_UNSUPPORTED;
        end
        `GRP_TESTREG: second_class = base;
        default:      second_class = `CL_UNSUPPORTED;
      endcase
    end
  endfunction

  // immediate bytes that follow the mod r/m byte
  function [2:0] modrm_imm;
    input [5:0] cls;
    input       w;
    begin
      case (cls)
        `CL_TEST_IMM,
        `CL_AND_IMM,
        `CL_OR_IMM,
        `CL_XOR_IMM: modrm_imm = w ? `LEN_WORD : `LEN_BYTE;
        default:     modrm_imm = `LEN_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // first byte classifier
  // ----------------------------------------
  wire [5:0] base_class;
  wire [2:0] base_group;
  wire [2:0] base_imm;

  opcode_classify u_classify (
    .opcode     (byte_data),
    .base_class (base_class),
    .group      (base_group),
    .imm_len    (base_imm)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [1:0] state_r;
  reg  [2:0] group_r;
  reg  [5:0] pend_class_r;
  reg  [2:0] byte_idx_r;

  // second byte decode, valid in the mod r/m state
  wire [5:0] sec_class;
  wire [1:0] sec_disp;
  wire [2:0] sec_imm;
  wire [2:0] sec_total;
  wire       sec_is_modrm;

  assign sec_is_modrm = (group_r != `GRP_ASCII2);
  assign sec_class    = second_class(group_r, byte_data, pend_class_r);
  assign sec_disp     = sec_is_modrm ? disp_bytes(byte_data) : 2'h0;
  assign sec_imm      = modrm_imm(sec_class, opcode_r[0]);
  assign sec_total    = {1'b0, sec_disp} + sec_imm;

  // last trailing byte of the current instruction
  wire trail_last = (byte_idx_r == trail_len_r - 3'h1);

  // ----------------------------------------
  // decoder sequence
  // ----------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r        <= `ST_OPCODE;
      group_r        <= `GRP_DIRECT;
      pend_class_r   <= `CL_UNSUPPORTED;
      byte_idx_r     <= 3'h0;
      op_valid_r     <= 1'b0;
      op_class_r     <= `CL_UNSUPPORTED;
      word_op_r      <= 1'b0;
      count_in_reg_r <= 1'b0;
      repeat_zero_r  <= 1'b0;
      has_modrm_r    <= 1'b0;
      opcode_r       <= 8'h00;
      modrm_r        <= 8'h00;
      disp_len_r     <= 2'h0;
      trail_len_r    <= 3'h0;
      operand_r      <= 32'h0000_0000;
    end else begin
      op_valid_r <= 1'b0;
      if (byte_valid) begin
        case (state_r)
          // first opcode byte
          `ST_OPCODE: begin
            opcode_r       <= byte_data;
            group_r        <= base_group;
            pend_class_r   <= base_class;
            op_class_r     <= base_class;
            word_op_r      <= byte_data[0];
            // v bit: count one or count from register
            count_in_reg_r <= (base_group == `GRP_SHIFT) &
                              byte_data[1];
            // z bit qualifies the repeat
            repeat_zero_r  <= (base_class == `CL_REPEAT_PREFIX) &
                              byte_data[0];
            has_modrm_r    <= (base_group != `GRP_DIRECT) &&
                              (base_group != `GRP_ASCII2);
            modrm_r        <= 8'h00;
            disp_len_r     <= 2'h0;
            trail_len_r    <= base_imm;
            operand_r      <= 32'h0000_0000;
            byte_idx_r     <= 3'h0;
            if (base_group != `GRP_DIRECT) begin
              state_r <= `ST_MODRM;
            end else if (base_imm != `LEN_NONE) begin
              state_r <= `ST_TRAIL;
            end else begin
              // single byte ops finish at once
              op_valid_r <= 1'b1;
              state_r    <= `ST_OPCODE;
            end
          end
          // second byte: mod r/m or fixed tail
          `ST_MODRM: begin
            op_class_r  <= sec_class;
            modrm_r     <= byte_data;
            disp_len_r  <= sec_disp;
            trail_len_r <= sec_total;
            byte_idx_r  <= 3'h0;
            if (sec_total != `LEN_NONE) begin
              state_r <= `ST_TRAIL;
            end else begin
              op_valid_r <= 1'b1;
              state_r    <= `ST_OPCODE;
            end
          end
          // displacement then immediate, low byte first
          `ST_TRAIL: begin
            case (byte_idx_r)
              3'h0:    operand_r[7:0]   <= byte_data;
              3'h1:    operand_r[15:8]  <= byte_data;
              3'h2:    operand_r[23:16] <= byte_data;
              default: operand_r[31:24] <= byte_data;
            endcase
            byte_idx_r <= byte_idx_r + 3'h1;
            if (trail_last) begin
              op_valid_r <= 1'b1;
              state_r    <= `ST_OPCODE;
            end
          end
          default: begin
            state_r <= `ST_OPCODE;
          end
        endcase
      end
    end
  end

endmodule // opcode_decode

`default_nettype wire

// ==== test/opcode_decode_sva.sv ====
// port checker for the opcode decoder, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module opcode_decode_chk (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        byte_valid,
  input wire logic [7:0]  byte_data,
  input wire logic        op_valid_r,
  input wire logic [5:0]  op_class_r,
  input wire logic        word_op_r,
  input wire logic        count_in_reg_r,
  input wire logic        repeat_zero_r,
  input wire logic        has_modrm_r,
  input wire logic [7:0]  opcode_r,
  input wire logic [7:0]  modrm_r,
  input wire logic [1:0]  disp_len_r,
  input wire logic [2:0]  trail_len_r,
  input wire logic [31:0] operand_r
);
  logic       first_r;
  wire        is_first;
  wire        one_b;
  wire  [2:0] disp3;
  wire  [2:0] imm3;

  // --------------------------------------
  // instruction boundary tracking
  // --------------------------------------
  // next byte taken opens an instruction
  assign is_first = first_r | op_valid_r;
  assign one_b = byte_data[7:2] == 6'b101001 ||
                 byte_data[7:1] inside {7'h55, 7'h56, 7'h57, 7'h79} ||
                 byte_data inside {8'h3F, 8'h2F, 8'h98, 8'h99,
                                   8'hC3, 8'hCB};
  assign disp3 = {1'b0, disp_len_r};
  assign imm3 = disp3 + 3'h1 + {2'h0, opcode_r[0]};

  // first-byte flag, cleared by any byte taken
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) first_r <= 1'b1;
    else first_r <= byte_valid ? 1'b0 : is_first;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------------
  // properties
  // --------------------------------------
  sequence s_lone;
    byte_valid && is_first && one_b;
  endsequence
  sequence s_lone_out;
    op_valid_r && opcode_r == $past(byte_data) && trail_len_r == 3'h0;
  endsequence
  property p_lone;
    s_lone |=> s_lone_out;
  endproperty
  property p_rep;
    op_valid_r && opcode_r[7:1] == 7'h79 |->
      op_class_r == 6'h06 && repeat_zero_r == opcode_r[0];
  endproperty
  property p_adj;
    op_valid_r && opcode_r[7:1] == 7'h6A && modrm_r == 8'h0A |->
      op_class_r == 6'h09 + {5'h0, opcode_r[0]};
  endproperty
  property p_muldiv;
    op_valid_r && opcode_r[7:1] == 7'h7B && modrm_r[5] |->
      op_class_r == 6'h0D + {4'h0, modrm_r[4:3]} && trail_len_r == disp3;
  endproperty
  property p_testimm;
    op_valid_r && opcode_r[7:1] == 7'h7B && modrm_r[5:3] == 3'h0 |->
      op_class_r == 6'h12 && trail_len_r == imm3;
  endproperty
  property p_shift;
    op_valid_r && opcode_r[7:2] == 6'h34 |->
      count_in_reg_r == opcode_r[1] && trail_len_r == disp3;
  endproperty
  property p_testreg;
    op_valid_r && opcode_r[7:1] == 7'h42 |->
      has_modrm_r && op_class_r == 6'h1A;
  endproperty
  property p_testacc;
    op_valid_r && opcode_r[7:1] == 7'h54 |->
      op_class_r == 6'h1B && trail_len_r == 3'h1 + {2'h0, opcode_r[0]};
  endproperty
  property p_near;
    op_valid_r && opcode_r inside {8'hE8, 8'hE9, 8'hC2} |->
      trail_len_r == 3'h2;
  endproperty
  property p_far;
    op_valid_r && opcode_r inside {8'h9A, 8'hEA} |->
      trail_len_r == 3'h4 && op_class_r inside {6'h22, 6'h23};
  endproperty
  property p_logimm;
    op_valid_r && opcode_r[7:1] == 7'h40 && modrm_r[5:4] == 2'b10 |->
      op_class_r == 6'h28 + {5'h0, modrm_r[3]} && trail_len_r == imm3;
  endproperty

  a_lone: assert property (p_lone)
    else $error("single byte op not answered");
  a_rep: assert property (p_rep)
    else $error("repeat prefix wrong");
  a_adj: assert property (p_adj)
    else $error("ascii adjust pair wrong");
  a_muldiv: assert property (p_muldiv)
    else $error("multiply or divide wrong");
  a_testimm: assert property (p_testimm)
    else $error("test immediate wrong");
  a_shift: assert property (p_shift)
    else $error("shift count source wrong");
  a_testreg: assert property (p_testreg)
    else $error("register test wrong");
  a_testacc: assert property (p_testacc)
    else $error("accumulator test wrong");
  a_near: assert property (p_near)
    else $error("near transfer length wrong");
  a_far: assert property (p_far)
    else $error("far transfer wrong");
  a_logimm: assert property (p_logimm)
    else $error("logic immediate wrong");
endmodule // opcode_decode_chk

bind opcode_decode opcode_decode_chk opcode_decode_chk_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .byte_valid(byte_valid),
  .byte_data(byte_data), .op_valid_r(op_valid_r), .op_class_r(op_class_r),
  .word_op_r(word_op_r), .count_in_reg_r(count_in_reg_r),
  .repeat_zero_r(repeat_zero_r), .has_modrm_r(has_modrm_r),
  .opcode_r(opcode_r), .modrm_r(modrm_r), .disp_len_r(disp_len_r),
  .trail_len_r(trail_len_r), .operand_r(operand_r)
);

`default_nettype wire

// ==== test/prog_mem_model.sv ====
// program memory model streaming instruction bytes to the decoder
`timescale 1ns/1ps
`default_nettype none

module prog_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       stall,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  logic [7:0] mem [$];
  logic       go;

  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end

  // one byte per cycle unless stalled; idle data toggles, never held
  always @(posedge sys_clk) begin
    go = reset_n && !stall && mem.size() > 0;
    #1;
    if (go) begin
      byte_valid = 1'b1;
      byte_data = mem.pop_front();
    end else begin
      byte_valid = 1'b0;
      byte_data = ~byte_data;
    end
  end
endmodule // prog_mem_model

`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        sys_clk;
  logic        reset_n;
  logic        stall;
  logic        gaps;
  logic [31:0] seed;
  logic [62:0] exp_q [$];
  logic [62:0] got;
  logic [62:0] exp;
  int          err_total;
  int          n_checks;
  wire         byte_valid;
  wire  [7:0]  byte_data;
  wire         op_valid_r;
  wire  [5:0]  op_class_r;
  wire         word_op_r;
  wire         count_in_reg_r;
  wire         repeat_zero_r;
  wire  [2:0]  trail_len_r;
  wire  [31:0] operand_r;
  wire  [7:0]  opcode_r;
  wire         has_modrm_r;
  wire  [7:0]  modrm_r;
  wire  [1:0]  disp_len_r;

  opcode_decode opcode_decode_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .op_valid_r(op_valid_r),
    .op_class_r(op_class_r), .word_op_r(word_op_r),
    .count_in_reg_r(count_in_reg_r), .repeat_zero_r(repeat_zero_r),
    .has_modrm_r(has_modrm_r), .opcode_r(opcode_r), .modrm_r(modrm_r),
    .disp_len_r(disp_len_r),
    .trail_len_r(trail_len_r), .operand_r(operand_r)
  );

  prog_mem_model prog_mem_model_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .stall(stall),
    .byte_valid(byte_valid), .byte_data(byte_data)
  );

  // --------------------------------------
  // helpers
  // --------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // queue one instruction and its expected decode
  task automatic ins(input logic [7:0] b0, input logic [7:0] b1,
                     input int nb, input int nd, input logic [5:0] cls);
    logic [31:0] opd;
    logic        hm;
    logic [1:0]  dl;
    opd = 32'h0000_0000;
    // mod r/m present unless it is the fixed 0a tail of an adjust pair
    hm = nb > 0 && b0[7:1] != 7'h6A;
    dl = 2'h0;
    if (hm && b1[7:6] == 2'h1) dl = 2'h1;
    if (hm && (b1[7:6] == 2'h2 || b1[7:6] == 2'h0 && b1[2:0] == 3'h6))
      dl = 2'h2;
    prog_mem_model_inst.mem.push_back(b0);
    if (nb > 0) prog_mem_model_inst.mem.push_back(b1);
    for (int k = 0; k < nd; k++) begin
      seed = xs(seed);
      opd[8*k +: 8] = seed[7:0];
      prog_mem_model_inst.mem.push_back(seed[7:0]);
    end
    exp_q.push_back({b0, ((nb > 0) ? b1 : 8'h00), hm, dl,
                     cls, b0[0], b0[7:2] == 6'b110100 && b0[1],
                     cls == 6'h06 && b0[0], nd[2:0], opd});
  endtask

  task automatic all_ops();
    logic [5:0] cls;
    ins(8'hA4, 8'h00, 0, 0, 6'h01);
    ins(8'hA7, 8'h00, 0, 0, 6'h02);
    ins(8'hF2, 8'h00, 0, 0, 6'h06);
    ins(8'hF3, 8'h00, 0, 0, 6'h06);
    ins(8'hAF, 8'h00, 0, 0, 6'h03);
    ins(8'hAC, 8'h00, 0, 0, 6'h04);
    ins(8'hAB, 8'h00, 0, 0, 6'h05);
    ins(8'h3F, 8'h00, 0, 0, 6'h07);
    ins(8'h2F, 8'h00, 0, 0, 6'h08);
    ins(8'hD4, 8'h0A, 1, 0, 6'h09);
    ins(8'hD5, 8'h0A, 1, 0, 6'h0A);
    ins(8'hD4, 8'h0B, 1, 0, 6'h00);
    ins(8'h98, 8'h00, 0, 0, 6'h0B);
    ins(8'h99, 8'h00, 0, 0, 6'h0C);
    ins(8'hF6, 8'hE0, 1, 0, 6'h0D);
    ins(8'hF7, 8'hE8, 1, 0, 6'h0E);
    ins(8'hF7, 8'hF0, 1, 0, 6'h0F);
    ins(8'hF6, 8'hF8, 1, 0, 6'h10);
    ins(8'hF7, 8'hD0, 1, 0, 6'h11);
    ins(8'hF7, 8'h46, 1, 3, 6'h12);
    ins(8'hF6, 8'hC0, 1, 1, 6'h12);
    ins(8'hF6, 8'hC8, 1, 0, 6'h00);
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      cls = (r == 6) ? 6'h00 : (r == 7) ? 6'h19 : 6'h13 + r[5:0];
      ins({6'b110100, seed[1:0]}, {2'b11, r[2:0], 3'h2}, 1, 0, cls);
    end
    ins(8'h85, 8'hC1, 1, 0, 6'h1A);
    ins(8'hA9, 8'h00, 0, 2, 6'h1B);
    ins(8'hA8, 8'h00, 0, 1, 6'h1B);
    ins(8'hC3, 8'h00, 0, 0, 6'h1C);
    ins(8'hCB, 8'h00, 0, 0, 6'h1D);
    ins(8'hC2, 8'h00, 0, 2, 6'h1E);
    ins(8'hE8, 8'h00, 0, 2, 6'h1F);
    ins(8'hE9, 8'h00, 0, 2, 6'h20);
    ins(8'hEB, 8'h00, 0, 1, 6'h21);
    ins(8'h9A, 8'h00, 0, 4, 6'h22);
    ins(8'hEA, 8'h00, 0, 4, 6'h23);
    ins(8'hFF, 8'hD0, 1, 0, 6'h24);
    ins(8'hFF, 8'h16, 1, 2, 6'h24);
    ins(8'hFF, 8'hD8, 1, 0, 6'h25);
    ins(8'hFF, 8'hE0, 1, 0, 6'h26);
    ins(8'hFF, 8'hE8, 1, 0, 6'h27);
    ins(8'h81, 8'hE0, 1, 2, 6'h28);
    ins(8'h80, 8'hE8, 1, 1, 6'h29);
    ins(8'h81, 8'hF0, 1, 2, 6'h2A);
    ins(8'h81, 8'hA0, 1, 4, 6'h28);
  endtask

  // wait until every queued byte is decoded, bounded
  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // --------------------------------------
  // clock, stall pattern, monitor
  // --------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // random stalls while gaps are enabled
  always @(posedge sys_clk) begin
    #1;
    seed = xs(seed);
    stall = gaps && seed[1:0] == 2'b00;
  end

  // compare each decode against the oldest expectation
  always @(posedge sys_clk) begin
    if (op_valid_r === 1'b1) begin
      got = {opcode_r, modrm_r, has_modrm_r, disp_len_r,
             op_class_r, word_op_r, count_in_reg_r, repeat_zero_r,
             trail_len_r, operand_r};
      exp = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n_checks++;
      if (got !== exp) begin
        err_total++;
        $display("MISMATCH op %h expected %h seen %h", opcode_r, exp, got);
      end
    end
  end

  // watchdog
  initial begin
    #100_000;
    err_total++;
    print_verdict();
  end

  // --------------------------------------
  // main sequence
  // --------------------------------------
  initial begin
    err_total = 0;
    n_checks = 0;
    seed = 32'h0000_043A;
    gaps = 1'b1;
    stall = 1'b0;
    reset_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    all_ops();
    drain();
    gaps = 1'b0;
    all_ops();
    drain();
    if (exp_q.size() > 0) err_total++;
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
